// [ssp_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package ssp_pkg;
    // register offsets
    localparam logic [15:0] ADDR_CTL_ONE = 16'h1240;
    localparam logic [15:0] ADDR_DATA = 16'h1241;
    localparam logic [15:0] ADDR_BITCNT = 16'h1242;
    localparam logic [15:0] ADDR_MODE_STAT = 16'h1243;
    localparam logic [15:0] ADDR_RATE_A = 16'h1244;
    localparam logic [15:0] ADDR_RATE_B = 16'h1245;
    // serial_control_one fields
    localparam int CTL_START_BIT = 7;
    localparam int CTL_INHIBIT_BIT = 6;
    localparam int CTL_TMODE_LSB = 4;
    localparam int CTL_CLK_LSB = 0;
    localparam logic [7:0] CTL_RESET = 8'h40;
    // serial_mode_control / serial_transfer_status fields
    localparam int MC_MASTER_BIT = 7;
    localparam int MC_DIR_BIT = 6;
    localparam int MC_BUSY_BIT = 5;
    localparam int MC_PEND_BIT = 4;
    localparam int MC_MODE_LSB = 2;
    localparam int ST_ACTIVE_BIT = 3;
    localparam int ST_SHIFT_BIT = 2;
    localparam int ST_LINE_BIT = 0;
    localparam int BC_LSB = 5;
    localparam int RATE_EN_BIT = 7;
    // operation modes and codes
    localparam logic [1:0] MODE_PORT = 2'h0;
    localparam logic [1:0] MODE_SHIFT = 2'h1;
    localparam logic [1:0] MODE_TWI = 2'h2;
    localparam logic [1:0] TMODE_TX = 2'h0;
    localparam logic [2:0] CLK_EXTERNAL = 3'h7;
    localparam logic [3:0] LAST_BIT = 4'h7;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TWI_HALF_NS = 5000;
    localparam int TWI_HALF_CYC = (TWI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] TWI_HALF_LIM = 10'(TWI_HALF_CYC - 1);
    localparam int DIV_BASE_LOG2 = 2;
    typedef enum logic [2:0] {TW_IDLE, TW_START, TW_STOP_LOW, TW_STOP_SCL, TW_STOP_SDA} ssp_tw_st_t;
    typedef enum logic [1:0] {SH_IDLE, SH_SHIFT, SH_WAIT} ssp_sh_st_t;
endpackage : ssp_pkg

// [ssp_sync.sv]
`timescale 1ns/1ns
// two-stage synchroniser for the three pin inputs
module ssp_sync (
    // clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // pins
    input wire logic [2:0] async_i,
    output logic [2:0] sync_o
);
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] stable;
    } ssp_sync_t;

    ssp_sync_t r, nxt;

    always_comb begin
        nxt.meta = async_i;
        nxt.stable = r.meta;
    end

    // lines idle high on the bus, so reset to 1
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '1;
        end else begin
            r <= nxt;
        end
    end

    assign sync_o = r.stable;
endmodule : ssp_sync

// [ssp_rate_div.sv]
`timescale 1ns/1ns
// half-period enable for the internal shift clock
module ssp_rate_div (
    // clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // control
    input wire logic run_i,
    input wire logic [2:0] sel_i,
    output logic tick_o
);
    typedef struct packed {
        logic [8:0] cnt;
        logic tick;
    } ssp_div_t;

    ssp_div_t r, nxt;
    logic [8:0] limit;

    always_comb begin
        limit = 9'((10'h004 << sel_i) - 10'h001);
        nxt = r;
        nxt.tick = 1'b0;
        if (!run_i) begin
            nxt.cnt = 9'h000;
        end else if (r.cnt >= limit) begin
            nxt.cnt = 9'h000;
            nxt.tick = 1'b1;
        end else begin
            nxt.cnt = r.cnt + 9'h001;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign tick_o = r.tick;
endmodule : ssp_rate_div

// [ssp_top.sv]
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
module ssp_top (
    // clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // register port
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // power state
    input wire logic light_standby_mode_i,
    // shift clock pin
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_o,
    // serial data out
    output logic so_o,
    output logic so_oe_o,
    // two-wire bus, open drain: oe high pulls low
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // interrupt request
    output logic buffer_interrupt_request_o
);

    //////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] rdata;
        logic [7:0] ctl_one;
        logic [2:0] bit_count_field;
        logic [1:0] operation_mode_field;
        logic master_select_bit;
        logic dir_bit;
        logic pend_bit;
        logic bus_busy_flag;
        logic [7:0] rate_a;
        logic rate_clock_enable;
        logic [7:0] data_buf;
        logic buf_full;
        ssp_pkg::ssp_tw_st_t tw_st;
        logic [9:0] tw_cnt;
        logic scl_drv;
        logic sda_drv;
        ssp_pkg::ssp_sh_st_t sh_st;
        logic [7:0] shreg;
        logic [3:0] bitn;
        logic sck_lvl;
        logic sck_prev;
        logic so;
        logic dummy;
        logic transfer_active_flag;
        logic shift_active_flag;
        logic irq;
        logic sck_oe;
        logic so_oe;
        logic scl_oe;
        logic sda_oe;
    } ssp_state_t;

    ssp_state_t r, nxt;
    logic [2:0] pins_s;
    logic sck_s;
    logic scl_s;
    logic sda_s;
    logic tick;
    logic div_run;

    //////////////////////////////////////////////////////////////////////////
    ssp_sync u_sync (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .async_i({sck_i, scl_i, sda_i}),
        .sync_o(pins_s)
    );

    assign sck_s = pins_s[2];
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // divider only runs while a word is actually moving
    assign div_run = (r.sh_st == ssp_pkg::SH_SHIFT) && r.rate_clock_enable
        && (r.ctl_one[ssp_pkg::CTL_CLK_LSB +: 3] != ssp_pkg::CLK_EXTERNAL);

    ssp_rate_div u_div (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .run_i(div_run),
        .sel_i(r.ctl_one[ssp_pkg::CTL_CLK_LSB +: 3]),
        .tick_o(tick)
    );

    //////////////////////////////////////////////////////////////////////////
    logic transfer_start_bit;
    logic inhibit;
    logic ext_clk;
    logic shift_ok;
    logic fall_ev;
    logic rise_ev;
    logic buf_write;
    logic mc_write;
    logic go_end;
    logic go_load;

    always_comb begin
        nxt = r;
        transfer_start_bit = r.ctl_one[ssp_pkg::CTL_START_BIT];
        inhibit = r.ctl_one[ssp_pkg::CTL_INHIBIT_BIT];
        ext_clk = r.ctl_one[ssp_pkg::CTL_CLK_LSB +: 3] == ssp_pkg::CLK_EXTERNAL;
        buf_write = wr_i && (addr_i == ssp_pkg::ADDR_DATA);
        mc_write = wr_i && (addr_i == ssp_pkg::ADDR_MODE_STAT);
        go_end = 1'b0;
        go_load = 1'b0;
        nxt.irq = 1'b0;
        nxt.sck_prev = sck_s;
        shift_ok = (r.operation_mode_field == ssp_pkg::MODE_SHIFT) && !light_standby_mode_i
            && (r.ctl_one[ssp_pkg::CTL_TMODE_LSB +: 2] == ssp_pkg::TMODE_TX);
        fall_ev = ext_clk ? (r.sck_prev && !sck_s) : (tick && r.sck_lvl);
        rise_ev = ext_clk ? (!r.sck_prev && sck_s) : (tick && !r.sck_lvl);

        //////////////////////////////////////////////////////////////////////
        // shift engine
        case (r.sh_st)
            ssp_pkg::SH_IDLE: begin
                if (shift_ok && transfer_start_bit && !inhibit && r.buf_full) begin
                    go_load = 1'b1;
                    nxt.transfer_active_flag = 1'b1;
                    nxt.dummy = 1'b0;
                    nxt.sck_lvl = 1'b1;
                    nxt.sh_st = ssp_pkg::SH_SHIFT;
                end
            end
            ssp_pkg::SH_SHIFT: begin
                if (fall_ev) begin
                    nxt.so = r.shreg[0];
                    nxt.shreg = {1'b1, r.shreg[7:1]};
                    nxt.shift_active_flag = 1'b1;
                    if (!ext_clk) begin
                        nxt.sck_lvl = 1'b0;
                    end
                end else if (rise_ev) begin
                    if (!ext_clk) begin
                        nxt.sck_lvl = 1'b1;
                    end
                    nxt.bitn = r.bitn + 4'h1;
                    if (r.bitn == ssp_pkg::LAST_BIT) begin
                        nxt.bitn = 4'h0;
                        nxt.shift_active_flag = 1'b0;
                        if (r.dummy || !transfer_start_bit) begin
                            go_end = 1'b1;
                        end else if (r.buf_full) begin
                            go_load = 1'b1;
                        end else if (ext_clk) begin
                            nxt.dummy = 1'b1;
                        end else begin
                            nxt.sh_st = ssp_pkg::SH_WAIT;
                        end
                    end
                end
            end
            ssp_pkg::SH_WAIT: begin
                nxt.sck_lvl = 1'b1;
                if (!transfer_start_bit) begin
                    go_end = 1'b1;
                end else if (r.buf_full) begin
                    go_load = 1'b1;
                    nxt.sh_st = ssp_pkg::SH_SHIFT;
                end
            end
            default: begin
                nxt.sh_st = ssp_pkg::SH_IDLE;
            end
        endcase

        if (go_load) begin
            nxt.shreg = r.data_buf;
            nxt.buf_full = 1'b0;
            nxt.irq = 1'b1;
        end
        if (r.sh_st != ssp_pkg::SH_IDLE && (inhibit || !shift_ok)) begin
            go_end = 1'b1;
        end
        if (go_end) begin
            nxt.sh_st = ssp_pkg::SH_IDLE;
            nxt.transfer_active_flag = 1'b0;
            nxt.shift_active_flag = 1'b0;
            nxt.bitn = 4'h0;
            nxt.sck_lvl = 1'b1;
            nxt.dummy = 1'b0;
        end

        //////////////////////////////////////////////////////////////////////
        // two-wire bus stop, start and release
        nxt.tw_cnt = (r.tw_cnt == ssp_pkg::TWI_HALF_LIM) ? r.tw_cnt : r.tw_cnt + 10'h001;
        case (r.tw_st)
            ssp_pkg::TW_IDLE: begin
                nxt.tw_cnt = 10'h000;
            end
            ssp_pkg::TW_START: begin
                nxt.sda_drv = 1'b1;
                if (r.tw_cnt == ssp_pkg::TWI_HALF_LIM) begin
                    nxt.scl_drv = 1'b1;
                    nxt.bus_busy_flag = 1'b1;
                    nxt.tw_st = ssp_pkg::TW_IDLE;
                end
            end
            ssp_pkg::TW_STOP_LOW: begin
                nxt.scl_drv = 1'b1;
                nxt.sda_drv = 1'b1;
                if (r.tw_cnt == ssp_pkg::TWI_HALF_LIM) begin
                    nxt.scl_drv = 1'b0;
                    nxt.tw_cnt = 10'h000;
                    nxt.tw_st = ssp_pkg::TW_STOP_SCL;
                end
            end
            ssp_pkg::TW_STOP_SCL: begin
                // wait for others to release SCL
                if (!scl_s) begin
                    nxt.tw_cnt = 10'h000;
                end else if (r.tw_cnt == ssp_pkg::TWI_HALF_LIM) begin
                    nxt.sda_drv = 1'b0;
                    nxt.tw_st = ssp_pkg::TW_STOP_SDA;
                end
            end
            ssp_pkg::TW_STOP_SDA: begin
                // stop complete once SDA and SCL both read high
                if (sda_s && scl_s) begin
                    nxt.bus_busy_flag = 1'b0;
                    nxt.tw_st = ssp_pkg::TW_IDLE;
                end
            end
            default: begin
                nxt.tw_st = ssp_pkg::TW_IDLE;
            end
        endcase

        //////////////////////////////////////////////////////////////////////
        // register writes
        if (wr_i) begin
            case (addr_i)
                ssp_pkg::ADDR_CTL_ONE: begin
                    // mode and clock taken as written
                    nxt.ctl_one = wdata_i;
                end
                ssp_pkg::ADDR_DATA: begin
                    nxt.data_buf = wdata_i;
                end
                ssp_pkg::ADDR_BITCNT: begin
                    nxt.bit_count_field = wdata_i[ssp_pkg::BC_LSB +: 3];
                end
                ssp_pkg::ADDR_MODE_STAT: begin
                    nxt.operation_mode_field = wdata_i[ssp_pkg::MC_MODE_LSB +: 2];
                    nxt.master_select_bit = wdata_i[ssp_pkg::MC_MASTER_BIT];
                    nxt.dir_bit = wdata_i[ssp_pkg::MC_DIR_BIT];
                    nxt.pend_bit = wdata_i[ssp_pkg::MC_PEND_BIT];
                end
                ssp_pkg::ADDR_RATE_A: begin
                    nxt.rate_a = wdata_i;
                end
                ssp_pkg::ADDR_RATE_B: begin
                    nxt.rate_clock_enable = wdata_i[ssp_pkg::RATE_EN_BIT];
                end
                default: begin
                end
            endcase
        end
        // a write refills the buffer; set wins over the engine's load
        if (buf_write) begin
            nxt.buf_full = 1'b1;
        end

        if (mc_write && r.tw_st == ssp_pkg::TW_IDLE) begin
            if (r.bus_busy_flag && wdata_i[7:4] == 4'hD) begin
                nxt.tw_cnt = 10'h000;
                nxt.tw_st = ssp_pkg::TW_STOP_LOW;
            end else if (wdata_i[7:4] == 4'h1) begin
                nxt.scl_drv = 1'b0;
                nxt.sda_drv = 1'b0;
                nxt.bus_busy_flag = 1'b0;
            end else if (!r.bus_busy_flag && wdata_i[ssp_pkg::MC_MASTER_BIT]
                    && wdata_i[ssp_pkg::MC_BUSY_BIT]) begin
                nxt.tw_cnt = 10'h000;
                nxt.tw_st = ssp_pkg::TW_START;
            end
        end

        //////////////////////////////////////////////////////////////////////
        // register reads, data one cycle later
        nxt.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                ssp_pkg::ADDR_CTL_ONE: begin
                    nxt.rdata = r.ctl_one;
                end
                ssp_pkg::ADDR_DATA: begin
                    nxt.rdata = r.data_buf;
                end
                ssp_pkg::ADDR_BITCNT: begin
                    nxt.rdata = {r.bit_count_field, 5'h00};
                end
                ssp_pkg::ADDR_MODE_STAT: begin
                    nxt.rdata[ssp_pkg::MC_MASTER_BIT] = r.master_select_bit;
                    nxt.rdata[ssp_pkg::MC_DIR_BIT] = r.dir_bit;
                    nxt.rdata[ssp_pkg::MC_BUSY_BIT] = r.bus_busy_flag;
                    nxt.rdata[ssp_pkg::MC_PEND_BIT] = r.pend_bit;
                    nxt.rdata[ssp_pkg::ST_ACTIVE_BIT] = r.transfer_active_flag;
                    nxt.rdata[ssp_pkg::ST_SHIFT_BIT] = r.shift_active_flag;
                    // line level lets software see SCL free
                    nxt.rdata[ssp_pkg::ST_LINE_BIT] = scl_s;
                end
                ssp_pkg::ADDR_RATE_A: begin
                    nxt.rdata = r.rate_a;
                end
                default: begin
                    nxt.rdata = 8'h00;
                end
            endcase
        end

        //////////////////////////////////////////////////////////////////////
        // pin drivers; port mode leaves every serial output off
        // internal clock driven out, external taken in
        nxt.sck_oe = (r.operation_mode_field == ssp_pkg::MODE_SHIFT) && !ext_clk;
        nxt.so_oe = r.operation_mode_field == ssp_pkg::MODE_SHIFT;
        nxt.scl_oe = (r.operation_mode_field == ssp_pkg::MODE_TWI) && nxt.scl_drv;
        nxt.sda_oe = (r.operation_mode_field == ssp_pkg::MODE_TWI) && nxt.sda_drv;
    end

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '0;
            r.ctl_one <= ssp_pkg::CTL_RESET;
            r.tw_st <= ssp_pkg::TW_IDLE;
            r.sh_st <= ssp_pkg::SH_IDLE;
            r.sck_lvl <= 1'b1;
            r.sck_prev <= 1'b1;
            r.so <= 1'b1;
            r.shreg <= 8'hFF;
        end else begin
            r <= nxt;
        end
    end

    assign rdata_o = r.rdata;
    assign sck_o = r.sck_lvl;
    assign sck_oe_o = r.sck_oe;
    assign so_o = r.so;
    assign so_oe_o = r.so_oe;
    assign scl_o = 1'b0;
    assign scl_oe_o = r.scl_oe;
    assign sda_o = 1'b0;
    assign sda_oe_o = r.sda_oe;
    assign buffer_interrupt_request_o = r.irq;
endmodule : ssp_top

// [ssp_properties.sv]
`timescale 1ns/1ns
module ssp_props (
    // clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // register port
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic light_standby_mode_i,
    // pins
    input wire logic sck_o,
    input wire logic sck_oe_o,
    input wire logic so_o,
    input wire logic so_oe_o,
    input wire logic scl_oe_o,
    input wire logic sda_oe_o,
    input wire logic buffer_interrupt_request_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    a_irq_single: assert property (buffer_interrupt_request_o |=> !buffer_interrupt_request_o)
        else $error("buffer request longer than one cycle");
    a_load_clk_high: assert property (buffer_interrupt_request_o |-> sck_o)
        else $error("buffer load while shift clock low");
    a_so_on_fall: assert property (sck_oe_o && $past(sck_oe_o) && $changed(so_o) |-> $fell(sck_o))
        else $error("data out changed off the falling clock edge");
    a_clk_high_min: assert property (sck_oe_o && $rose(sck_o) |=> sck_o [*3])
        else $error("shift clock high phase shorter than four cycles");
    a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside the read answer cycle");
    a_standby_frozen: assert property (light_standby_mode_i && $past(light_standby_mode_i) &&
        $past(light_standby_mode_i, 2) |-> $stable(sck_o) && $stable(so_o))
        else $error("shift pins moved in light standby");
    a_pin_mode_excl: assert property (sck_oe_o |-> so_oe_o && !scl_oe_o && !sda_oe_o)
        else $error("shift clock driven outside shift mode");
    a_stop_sda_last: assert property ($fell(sda_oe_o) |-> !scl_oe_o)
        else $error("data line released while clock line held");
    a_stop_order: assert property ($fell(scl_oe_o) && sda_oe_o |=> sda_oe_o [*8])
        else $error("stop released data line too early");
endmodule : ssp_props

bind ssp_top ssp_props u_ssp_props (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .light_standby_mode_i(light_standby_mode_i),
    .sck_o(sck_o),
    .sck_oe_o(sck_oe_o),
    .so_o(so_o),
    .so_oe_o(so_oe_o),
    .scl_oe_o(scl_oe_o),
    .sda_oe_o(sda_oe_o),
    .buffer_interrupt_request_o(buffer_interrupt_request_o)
);

// [ssp_peer.sv]
`timescale 1ns/1ns
module ssp_peer (
    // design pins
    input wire logic sck_o,
    input wire logic sck_oe_o,
    input wire logic so_o,
    input wire logic so_oe_o,
    input wire logic scl_oe_o,
    input wire logic sda_oe_o,
    // bench control
    input wire logic hold_scl_i,
    // resolved lines
    output logic sck_line_o,
    output logic scl_line_o,
    output logic sda_line_o,
    // received data
    output logic [7:0] rx_byte_o,
    output int rx_bits_o
);
    logic ext_sck;
    initial begin
        ext_sck = 1'b1;
        rx_byte_o = 8'h00;
        rx_bits_o = 0;
    end
    assign sck_line_o = sck_oe_o ? sck_o : ext_sck;
    // another device may hold clock low; both lines pulled up
    assign scl_line_o = !(scl_oe_o || hold_scl_i);
    assign sda_line_o = !sda_oe_o;
    always @(posedge sck_line_o) begin
        if (so_oe_o === 1'b1) begin
            rx_byte_o = {so_o, rx_byte_o[7:1]};
            rx_bits_o++;
        end
    end
    // external clock, 125 ns, idle high between frames
    task automatic ext_byte();
        for (int i = 0; i < 8; i++) begin
            #63 ext_sck = 1'b0;
            #62 ext_sck = 1'b1;
        end
    endtask : ext_byte
endmodule : ssp_peer

// [tb_serial_bus_sync_shift_port.sv]
`timescale 1ns/1ns
module tb_serial_bus_sync_shift_port;
    logic clock_i, rstn_i, wr_i, rd_i, standby, hold_scl;
    logic [15:0] addr_i;
    logic [7:0] wdata_i, rdata_o, rx_byte, d, b0, b1;
    logic sck_line, sck_o, sck_oe_o, so_o, so_oe_o, scl_line, scl_oe_o, sda_line, sda_oe_o, irq;
    logic [2:0] sel;
    int rx_bits, irq_count, fail_count, num_checks, n, bits;
    ssp_top uut (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .light_standby_mode_i(standby),
        .sck_i(sck_line), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .so_o(so_o), .so_oe_o(so_oe_o),
        .scl_i(scl_line), .scl_o(), .scl_oe_o(scl_oe_o), .sda_i(sda_line), .sda_o(),
        .sda_oe_o(sda_oe_o), .buffer_interrupt_request_o(irq));
    ssp_peer u_peer (.sck_o(sck_o), .sck_oe_o(sck_oe_o), .so_o(so_o), .so_oe_o(so_oe_o),
        .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o), .hold_scl_i(hold_scl), .sck_line_o(sck_line),
        .scl_line_o(scl_line), .sda_line_o(sda_line), .rx_byte_o(rx_byte), .rx_bits_o(rx_bits));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) if (irq === 1'b1) irq_count++;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] b8(input logic x);
        return {7'h00, x};
    endfunction : b8
    function automatic logic [7:0] ctl(input logic st, input logic inh, input logic [2:0] s);
        return {st, inh, ssp_pkg::TMODE_TX, 1'b0, s};
    endfunction : ctl
    function automatic logic [7:0] mc(input logic [3:0] hi, input logic [1:0] mode);
        return {hi, mode, 2'h0};
    endfunction : mc
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic give_up(input string name);
        check(name, 8'h00, 8'h01);
        end_of_test();
    endtask : give_up
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : rd_reg
    task automatic wait_stat(input int b, input logic v);
        for (int i = 0; i < 1000; i++) begin
            rd_reg(ssp_pkg::ADDR_MODE_STAT, d);
            if (d[b] === v) return;
        end
        give_up("status wait");
    endtask : wait_stat
    task automatic wait_ev(input int irqs, input int nbits);
        for (int i = 0; i < 5000; i++) begin
            @(posedge clock_i);
            if (irq_count >= irqs && rx_bits >= nbits) return;
        end
        give_up("event wait");
    endtask : wait_ev
    task automatic send(input logic [2:0] s, input logic [7:0] v);
        n = irq_count;
        bits = rx_bits;
        wr_reg(ssp_pkg::ADDR_DATA, v);
        wr_reg(ssp_pkg::ADDR_CTL_ONE, ctl(1'b1, 1'b0, s));
        wait_ev(n + 1, 0);
    endtask : send
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn_i, wr_i, rd_i, standby, hold_scl, addr_i, wdata_i, sel} = '0;
        void'($urandom(32'hE8DDEBED));
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        rd_reg(ssp_pkg::ADDR_CTL_ONE, d);
        check("ctl_reset", d, ssp_pkg::CTL_RESET);
        check("port_mode", {6'h00, so_oe_o, scl_oe_o}, 8'h00);
        b0 = 8'($urandom);
        wr_reg(ssp_pkg::ADDR_RATE_A, b0);
        rd_reg(ssp_pkg::ADDR_RATE_A, d);
        check("rate_a", d, b0);
        rd_reg(ssp_pkg::ADDR_RATE_B, d);
        check("rate_b_wo", d, 8'h00);
        rd_reg(16'h1250, d);
        check("unmapped", d, 8'h00);
        wr_reg(ssp_pkg::ADDR_RATE_B, 8'h80);
        // bit count cleared before shift mode
        wr_reg(ssp_pkg::ADDR_BITCNT, 8'h00);
        wr_reg(ssp_pkg::ADDR_MODE_STAT, mc(4'h0, ssp_pkg::MODE_SHIFT));
        for (int k = 0; k < 3; k++) begin
            wr_reg(ssp_pkg::ADDR_CTL_ONE, ctl(1'b0, 1'b1, sel));
            sel = (k == 0) ? 3'h0 : 3'($urandom_range(2, 1));
            b0 = (k == 0) ? 8'h80 : 8'($urandom);
            b1 = 8'($urandom);
            wr_reg(ssp_pkg::ADDR_CTL_ONE, ctl(1'b0, 1'b1, sel));
            wr_reg(ssp_pkg::ADDR_CTL_ONE, ctl(1'b0, 1'b0, sel));
            send(sel, b0);
            wait_ev(0, bits + 8);
            check("rx_first", rx_byte, b0);
            repeat (80) @(posedge clock_i);
            check("sck_waits", b8(sck_o), 8'h01);
            check("no_extra", 8'(rx_bits - bits), 8'h08);
            rd_reg(ssp_pkg::ADDR_MODE_STAT, d);
            check("active_wait", b8(d[ssp_pkg::ST_ACTIVE_BIT]), 8'h01);
            wr_reg(ssp_pkg::ADDR_DATA, b1);
            wait_ev(n + 2, 0);
            wr_reg(ssp_pkg::ADDR_CTL_ONE, ctl(1'b0, 1'b0, sel));
            wait_ev(0, bits + 16);
            wait_stat(ssp_pkg::ST_ACTIVE_BIT, 1'b0);
            check("flags_end", {6'h00, d[3:2]}, 8'h00);
            check("rx_second", rx_byte, b1);
            check("so_hold", b8(so_o), b8(b1[7]));
        end
        // abort mid-word: light standby, then inhibit
        for (int k = 0; k < 2; k++) begin
            send(sel, 8'($urandom));
            wait_ev(0, bits + 3);
            standby <= (k == 0);
            if (k == 1) wr_reg(ssp_pkg::ADDR_CTL_ONE, ctl(1'b1, 1'b1, sel));
            bits = rx_bits;
            repeat (120) @(posedge clock_i);
            standby <= 1'b0;
            repeat (80) @(posedge clock_i);
            check("abort_bits", 8'(rx_bits - bits), 8'h00);
            rd_reg(ssp_pkg::ADDR_MODE_STAT, d);
            check("abort_flags", {6'h00, d[3:2]}, 8'h00);
            wr_reg(ssp_pkg::ADDR_CTL_ONE, ctl(1'b0, 1'b1, sel));
        end
        // external clock, then the dummy word when start is left set
        b0 = 8'($urandom);
        wr_reg(ssp_pkg::ADDR_CTL_ONE, ctl(1'b0, 1'b1, ssp_pkg::CLK_EXTERNAL));
        wr_reg(ssp_pkg::ADDR_CTL_ONE, ctl(1'b0, 1'b0, ssp_pkg::CLK_EXTERNAL));
        send(ssp_pkg::CLK_EXTERNAL, b0);
        // start cleared before the next shift
        wr_reg(ssp_pkg::ADDR_CTL_ONE, ctl(1'b0, 1'b0, ssp_pkg::CLK_EXTERNAL));
        u_peer.ext_byte();
        wait_stat(ssp_pkg::ST_ACTIVE_BIT, 1'b0);
        check("ext_rx", rx_byte, b0);
        send(ssp_pkg::CLK_EXTERNAL, 8'($urandom));
        u_peer.ext_byte();
        u_peer.ext_byte();
        wait_stat(ssp_pkg::ST_ACTIVE_BIT, 1'b0);
        check("dummy", rx_byte, 8'hFF);
        // two-wire: start, stop held off by the peer, then release for restart
        wr_reg(ssp_pkg::ADDR_MODE_STAT, mc(4'h0, ssp_pkg::MODE_TWI));
        wr_reg(ssp_pkg::ADDR_MODE_STAT, mc(4'hA, ssp_pkg::MODE_TWI));
        repeat (1100) @(posedge clock_i);
        check("start_lines", {6'h00, scl_oe_o, sda_oe_o}, 8'h03);
        hold_scl <= 1'b1;
        // control left untouched until the stop shows
        wr_reg(ssp_pkg::ADDR_MODE_STAT, mc(4'hD, ssp_pkg::MODE_TWI));
        repeat (1500) @(posedge clock_i);
        check("stop_held", b8(sda_oe_o), 8'h01);
        hold_scl <= 1'b0;
        wait_stat(ssp_pkg::MC_BUSY_BIT, 1'b0);
        check("stop_lines", {6'h00, scl_line, sda_line}, 8'h03);
        wr_reg(ssp_pkg::ADDR_MODE_STAT, mc(4'hA, ssp_pkg::MODE_TWI));
        repeat (1100) @(posedge clock_i);
        wr_reg(ssp_pkg::ADDR_MODE_STAT, mc(4'h1, ssp_pkg::MODE_TWI));
        repeat (2) @(posedge clock_i);
        check("release", {6'h00, scl_oe_o, sda_oe_o}, 8'h00);
        // poll busy, then line level, before restarting
        wait_stat(ssp_pkg::MC_BUSY_BIT, 1'b0);
        wait_stat(ssp_pkg::ST_LINE_BIT, 1'b1);
        // bus free time before the new start
        repeat (470) @(posedge clock_i);
        wr_reg(ssp_pkg::ADDR_MODE_STAT, mc(4'hA, ssp_pkg::MODE_TWI));
        wait_stat(ssp_pkg::MC_BUSY_BIT, 1'b1);
        end_of_test();
    end
endmodule : tb_serial_bus_sync_shift_port
